// [rtl/gain_sel_pkg.sv]
/*
  Package for the servo gain set selector: register map, field layouts,
  reset values, mode codes and timing constants.
  Assumes a 20 MHz core clock and an Avalon-MM slave with 32-bit data.
*/
package gain_sel_pkg;

  // Core clock rate and the delay step of the return timer
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned DELAY_STEP_US   = 100;  // 0.1 ms per delay count
  localparam int unsigned DELAY_STEP_CYC  = (CLK_HZ / 1_000_000) * DELAY_STEP_US;
  localparam logic [11:0] DELAY_STEP_LAST = 12'(DELAY_STEP_CYC - 1);

  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_DELAY  = 4'h4;
  localparam logic [3:0] ADDR_LEVEL  = 4'h8;
  localparam logic [3:0] ADDR_HYST   = 4'hc;

  // Control register field positions
  localparam int unsigned CTRL_MODE_LSB   = 0;   // 4-bit switch mode
  localparam int unsigned CTRL_ENABLE_BIT = 4;   // second gain enable
  localparam int unsigned CTRL_SEL_BIT    = 8;   // read-only: gain set in use
  localparam int unsigned CTRL_TIMING_BIT = 9;   // read-only: return timer busy

  // Reset values and limits
  localparam logic [3:0]  MODE_RST    = 4'h0;
  localparam logic        ENABLE_RST  = 1'b1;
  localparam logic [13:0] DELAY_RST   = 14'h000a;
  localparam logic [13:0] DELAY_MAX   = 14'h2710;  // 10000
  localparam logic [14:0] LEVEL_RST   = 15'h0000;
  localparam logic [14:0] HYST_RST    = 15'h0000;
  localparam logic [14:0] SETTING_MAX = 15'h4e20;  // 20000

  // Switch modes
  localparam logic [3:0] MODE_FIX1   = 4'h0;
  localparam logic [3:0] MODE_FIX2   = 4'h1;
  localparam logic [3:0] MODE_INPUT  = 4'h2;
  localparam logic [3:0] MODE_TORQUE = 4'h3;
  localparam logic [3:0] MODE_SPDCMD = 4'h5;
  localparam logic [3:0] MODE_DEV    = 4'h6;
  localparam logic [3:0] MODE_POSCMD = 4'h7;
  localparam logic [3:0] MODE_INPOS  = 4'h8;
  localparam logic [3:0] MODE_SPEED  = 4'h9;
  localparam logic [3:0] MODE_CMDSPD = 4'ha;

  // Measurements from the control loops, magnitudes in mode units
  typedef struct packed {
    logic [15:0] torque_mag;     // Torque command magnitude, percent
    logic [15:0] speed_cmd_mag;  // Speed command magnitude, r/min
    logic [15:0] speed_mag;      // Actual speed magnitude, r/min
    logic [15:0] dev_enc_mag;    // Deviation in encoder units
    logic [15:0] dev_ext_mag;    // Deviation in external scale units
    logic        pos_cmd_nonzero;
    logic        pos_complete;
  } loop_meas_t;

  // Drive control mode flags
  typedef struct packed {
    logic position_ctl;
    logic full_closed_ctl;
  } ctl_mode_t;

  // Avalon-MM slave signals
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avl_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avl_rsp_t;

endpackage : gain_sel_pkg

// [rtl/pin_sync3.sv]
/*
  Three-stage input synchroniser with agreement filter.
  Assumes one core clock; the input may change at any time.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output var  logic level_r
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Shift chain; the level moves only once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule : pin_sync3
`default_nettype wire

// [rtl/gain_set_selector.sv]
/*
  Servo gain set selector: chooses first or second gain set for position
  and full-closed control from the configured trigger mode, with level,
  hysteresis and a return delay. Settings sit behind an Avalon-MM slave.
  Assumes a single 20 MHz clock, asynchronous active-high reset, and loop
  measurements already synchronous to core_clk.
*/
// Functional notes
// - Mode 0 fixes first gain, mode 1 fixes second gain.
// - Second gain in modes 1 to 10 only when second gain enable is 1; else first gain.
// - Mode 2: input open gives first gain, tied to common gives second.
// - Mode 2 without an assigned input holds first gain.
// - Mode 3: torque above level plus hysteresis, return after delay below.
// - Mode 5: speed command above level plus hysteresis, delayed return.
// - Mode 6: position deviation above level plus hysteresis, delayed return.
// - Mode 6 uses encoder units in position, scale units in full-closed.
// - Mode 7: nonzero position command enters; zero for delay returns.
// - Mode 8: incomplete positioning enters; completion for delay returns.
// - Mode 9: actual speed above level plus hysteresis, delayed return.
// - Mode 10: command nonzero enters; zero command and low speed return.
// - Modes 5 to 10 act only in position or full-closed control.
// - Delay 0 to 10000 steps of 0.1 ms, default 10, timed modes.
// - Level 0 to 20000, default 0, used in modes 3,5,6,9,10.
// - Hysteresis 0 to 20000, default 0, same modes.
// - Level below hysteresis makes effective hysteresis equal level.
`timescale 1ns/1ps
`default_nettype none
module gain_set_selector (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire gain_sel_pkg::avl_req_t  avl_req,
  output var  gain_sel_pkg::avl_rsp_t  avl_rsp,
  input  wire gain_sel_pkg::loop_meas_t meas,
  input  wire gain_sel_pkg::ctl_mode_t ctl_mode,
  input  wire logic                    gain_in_closed,
  input  wire logic                    gain_in_assigned,
  output var  logic                    second_gain_r
);
  import gain_sel_pkg::*;

  typedef enum logic [1:0] {
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } sel_state_t;

  // Settings
  logic [3:0]  position_switch_mode_r;
  logic        second_gain_enable_r;
  logic [13:0] return_delay_setting_r;
  logic [14:0] switch_level_setting_r;
  logic [14:0] switch_hysteresis_setting_r;

  sel_state_t  state_r;
  sel_state_t  state_nxt;
  logic [11:0] step_cnt_r;
  logic [13:0] delay_cnt_r;
  logic        ack_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        gain_pin_level;

  // Synchronised gain select input (closed to common return = high)
  pin_sync3 u_gain_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (gain_in_closed),
    .level_r  (gain_pin_level)
  );

  // Bus decode: one wait cycle, then acknowledge
  wire         bus_req   = avl_req.read | avl_req.write;
  wire         bus_take  = bus_req & ~ack_r;
  // A write lands only at the edge where waitrequest is seen low
  wire         wr_take   = ack_r & avl_req.write;
  // Register select
  wire         sel_ctrl  = avl_req.address == ADDR_CTRL;
  wire         sel_delay = avl_req.address == ADDR_DELAY;
  wire         sel_level = avl_req.address == ADDR_LEVEL;
  wire         sel_hyst  = avl_req.address == ADDR_HYST;
  wire [31:0]  wd        = avl_req.writedata;
  wire [3:0]   be        = avl_req.byteenable;

  // Write values with byte lanes; unused lanes read as zero
  wire [15:0]  wd_lo     = {be[1] ? wd[15:8] : 8'h00, be[0] ? wd[7:0] : 8'h00};

  // Out-of-range settings clamp to the largest legal value
  wire         delay_over = (wd_lo[13:0] > DELAY_MAX) || (wd_lo[15:14] != 2'b00);
  wire         set_over   = (wd_lo[14:0] > SETTING_MAX) || wd_lo[15];
  wire [13:0]  delay_in   = delay_over ? DELAY_MAX : wd_lo[13:0];
  wire [14:0]  set_in     = set_over ? SETTING_MAX : wd_lo[14:0];

  // Setting words are only taken with both low byte lanes
  wire         lanes_lo   = be[0] & be[1];

  wire [14:0]  hyst_eff  = (switch_level_setting_r < switch_hysteresis_setting_r) ?
                           switch_level_setting_r : switch_hysteresis_setting_r;
  // Thresholds: level plus and minus the effective hysteresis
  wire [15:0]  thr_up    = {1'b0, switch_level_setting_r} + {1'b0, hyst_eff};
  wire [15:0]  thr_down  = {1'b0, switch_level_setting_r} - {1'b0, hyst_eff};

  // Position-family modes need position or full-closed control
  wire         pos_ctl_any = ctl_mode.position_ctl | ctl_mode.full_closed_ctl;

  // Deviation unit follows the control mode
  wire [15:0]  dev_mag   = ctl_mode.full_closed_ctl ? meas.dev_ext_mag : meas.dev_enc_mag;

  // Magnitude selected by mode for the level-based triggers
  logic [15:0] mag_sel;
  always_comb begin
    unique case (position_switch_mode_r)
      MODE_TORQUE: mag_sel = meas.torque_mag;
      MODE_SPDCMD: mag_sel = meas.speed_cmd_mag;
      MODE_DEV:    mag_sel = dev_mag;
      // Actual speed, also for mode 10 return
      default:     mag_sel = meas.speed_mag;
    endcase
  end

  // Strict compares: exceed to enter, stay below to return
  wire         mag_above = mag_sel > thr_up;
  wire         mag_below = mag_sel < thr_down;

  // Enter and return conditions per mode
  logic enter_c;
  logic return_c;
  logic trig_mode;
  always_comb begin
    enter_c   = 1'b0;
    return_c  = 1'b1;
    trig_mode = 1'b0;
    unique case (position_switch_mode_r)
      // Torque trigger in every control mode
      MODE_TORQUE: begin
        trig_mode = 1'b1;
        enter_c   = mag_above;
        return_c  = mag_below;
      end
      MODE_SPDCMD, MODE_DEV, MODE_SPEED: begin
        trig_mode = pos_ctl_any;
        enter_c   = mag_above;
        return_c  = mag_below;
      end
      MODE_POSCMD: begin
        trig_mode = pos_ctl_any;
        enter_c   = meas.pos_cmd_nonzero;
        return_c  = ~meas.pos_cmd_nonzero;
      end
      MODE_INPOS: begin
        trig_mode = pos_ctl_any;
        enter_c   = ~meas.pos_complete;
        return_c  = meas.pos_complete;
      end
      MODE_CMDSPD: begin
        trig_mode = pos_ctl_any;
        enter_c   = meas.pos_cmd_nonzero;
        return_c  = ~meas.pos_cmd_nonzero & mag_below;
      end
      // Fixed, input and undefined modes never trigger
      default: begin
        trig_mode = 1'b0;
        enter_c   = 1'b0;
        return_c  = 1'b1;
      end
    endcase
  end

  // Delay done once the count reaches the setting
  wire         step_tick  = step_cnt_r == DELAY_STEP_LAST;
  wire         delay_done = delay_cnt_r >= return_delay_setting_r;

  wire         fixed_second = position_switch_mode_r == MODE_FIX2;
  wire         input_second = (position_switch_mode_r == MODE_INPUT) & gain_in_assigned & gain_pin_level;
  wire         use_trig     = second_gain_enable_r & trig_mode;
  wire         direct_sec   = second_gain_enable_r & (fixed_second | input_second);

  // Next state of the triggered selection
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_FIRST: begin
        if (use_trig && enter_c) begin
          state_nxt = ST_SECOND;
        end
      end
      ST_SECOND: begin
        // Leaving trigger switching drops at once
        if (!use_trig) begin
          state_nxt = ST_FIRST;
        // Otherwise wait for the delay to run out
        end else if (return_c && delay_done) begin
          state_nxt = ST_FIRST;
        end
      end
      default: state_nxt = ST_FIRST;
    endcase
  end

  // Return timer restarts whenever the return condition lapses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_cnt_r  <= 12'h000;
      delay_cnt_r <= 14'h0000;
    end else if (state_r != ST_SECOND || !return_c || !use_trig) begin
      step_cnt_r  <= 12'h000;
      delay_cnt_r <= 14'h0000;
    end else begin
      // Count 0.1 ms steps while the return condition holds
      step_cnt_r <= step_tick ? 12'h000 : step_cnt_r + 12'h001;
      if (step_tick && !delay_done) begin
        delay_cnt_r <= delay_cnt_r + 14'h0001;
      end
    end
  end

  // Selection state and registered output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r       <= ST_FIRST;
      second_gain_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      // Unlisted modes fall to first gain
      second_gain_r <= direct_sec | (use_trig & (state_nxt == ST_SECOND));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      position_switch_mode_r      <= MODE_RST;
      second_gain_enable_r        <= ENABLE_RST;
      return_delay_setting_r      <= DELAY_RST;
      switch_level_setting_r      <= LEVEL_RST;
      switch_hysteresis_setting_r <= HYST_RST;
    end else if (wr_take) begin
      if (sel_ctrl && be[0]) begin
        position_switch_mode_r <= wd[CTRL_MODE_LSB +: 4];
        second_gain_enable_r   <= wd[CTRL_ENABLE_BIT];
      end
      if (sel_delay && lanes_lo) begin
        return_delay_setting_r <= delay_in;
      end
      if (sel_level && lanes_lo) begin
        switch_level_setting_r <= set_in;
      end
      if (sel_hyst && lanes_lo) begin
        switch_hysteresis_setting_r <= set_in;
      end
    end
  end

  // Return timer shows busy once a delay step has been counted
  wire         timer_busy = delay_cnt_r != 14'h0000;

  // Control word read-back, fields at their register positions
  logic [31:0] ctrl_rd;
  always_comb begin
    ctrl_rd                     = 32'h00000000;
    ctrl_rd[CTRL_MODE_LSB +: 4] = position_switch_mode_r;
    ctrl_rd[CTRL_ENABLE_BIT]    = second_gain_enable_r;
    ctrl_rd[CTRL_SEL_BIT]       = second_gain_r;
    ctrl_rd[CTRL_TIMING_BIT]    = timer_busy;
  end

  // Read data mux; unmapped reads give zero
  wire [31:0] rd_mux  = sel_ctrl  ? ctrl_rd :
                        sel_delay ? {18'h00000, return_delay_setting_r} :
                        sel_level ? {17'h00000, switch_level_setting_r} :
                        sel_hyst  ? {17'h00000, switch_hysteresis_setting_r} : 32'h00000000;

  // Bus handshake: waitrequest high until the second cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= bus_take;
      wait_r  <= ~bus_take;
      rdata_r <= bus_take ? rd_mux : rdata_r;
    end
  end

  // Bus outputs straight from their registers
  assign avl_rsp.readdata    = rdata_r;
  assign avl_rsp.waitrequest = wait_r;

endmodule : gain_set_selector
`default_nettype wire

// [test/gain_pin_host.sv]
/*
  Host model driving the gain select pin and its assignment.
  Assumes the pin moves with no relation to the core clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module gain_pin_host (
  input  wire logic close_req,
  input  wire logic assign_req,
  output var  logic gain_in_closed,
  output wire logic gain_in_assigned
);
  // contact lands off the edge, open at start
  initial begin
    gain_in_closed = 1'b0;
    forever @(close_req) gain_in_closed <= #13 close_req;
  end
  // Assignment is a static setting
  assign gain_in_assigned = assign_req;
endmodule : gain_pin_host
`default_nettype wire

// [test/gain_sel_checker.sv]
/*
  Port checker for the gain set selector.
  Assumes it is bound to gain_set_selector and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module gain_sel_checker (
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire gain_sel_pkg::avl_req_t   avl_req,
  input wire gain_sel_pkg::avl_rsp_t   avl_rsp,
  input wire gain_sel_pkg::loop_meas_t meas,
  input wire gain_sel_pkg::ctl_mode_t  ctl_mode,
  input wire logic                     gain_in_closed,
  input wire logic                     gain_in_assigned,
  input wire logic                     second_gain_r
);
  import gain_sel_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] mode_r;
  logic       en_r;
  // Decodes for the shadow and the assertions
  wire        ctrl_wr = avl_req.write && avl_req.address == ADDR_CTRL && avl_req.byteenable[0] && !avl_rsp.waitrequest;
  wire        pin_sel = en_r && mode_r == MODE_INPUT && gain_in_assigned;
  wire        no_ctl  = !ctl_mode.position_ctl && !ctl_mode.full_closed_ctl;
  // Shadow of control word, loads at the same edge as the DUT register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RST;
      en_r   <= ENABLE_RST;
    end else if (ctrl_wr) begin
      mode_r <= avl_req.writedata[3:0];
      en_r   <= avl_req.writedata[4];
    end
  end
  property p_answer; (avl_req.read || avl_req.write) && avl_rsp.waitrequest |-> ##[1:2] !avl_rsp.waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_pulse; !avl_rsp.waitrequest |=> avl_rsp.waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_fixed; en_r && mode_r <= MODE_FIX2 && $stable(mode_r) && $stable(en_r) |->
    second_gain_r == mode_r[0]; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode wrong");
  property p_enable; !en_r && $stable(en_r) |-> !second_gain_r; endproperty
  a_enable: assert property (p_enable) else $error("second gain while disabled");
  property p_pin; (pin_sel && $stable(gain_in_closed)) [*8] |-> second_gain_r == gain_in_closed; endproperty
  a_pin: assert property (p_pin) else $error("pin mode wrong");
  property p_unassigned; (en_r && mode_r == MODE_INPUT && !gain_in_assigned) [*2] |-> !second_gain_r; endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned pin not first");
  property p_ctl; (mode_r >= MODE_SPDCMD && mode_r <= MODE_CMDSPD && no_ctl) [*2] |-> !second_gain_r; endproperty
  a_ctl: assert property (p_ctl) else $error("trigger outside position control");
  property p_undefined; (mode_r == 4'h4 || mode_r > MODE_CMDSPD) && $stable(mode_r) |-> !second_gain_r; endproperty
  a_undefined: assert property (p_undefined) else $error("undefined mode not first");
  property p_cmd_entry; $rose(second_gain_r) && mode_r == MODE_POSCMD && $stable(mode_r) |-> $past(meas.pos_cmd_nonzero);
  endproperty
  a_cmd_entry: assert property (p_cmd_entry) else $error("entry without command");
endmodule : gain_sel_checker
bind gain_set_selector gain_sel_checker u_chk (.core_clk, .rst, .avl_req, .avl_rsp, .meas, .ctl_mode,
  .gain_in_closed, .gain_in_assigned, .second_gain_r);
`default_nettype wire

// [test/tb_gain_set_selector.sv]
/*
  Self-checking bench for the gain set selector.
  Assumes the bound checker and the gain pin host model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gain_set_selector;
  import gain_sel_pkg::*;
  logic        core_clk   = 1'b0;
  logic        rst        = 1'b1;
  avl_req_t    req        = '0;
  avl_rsp_t    rsp;
  loop_meas_t  meas       = '0;
  ctl_mode_t   ctl_mode   = 2'h2;  // Position control
  logic        close_req  = 1'b0;
  logic        assign_req = 1'b1;
  logic        pin_closed;
  wire         pin_assigned;
  logic        sel;
  logic [3:0]  be         = 4'hf;
  logic [31:0] q;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  logic [4:0]  fixm[6]    = '{5'h10, 5'h11, 5'h01, 5'h14, 5'h1b, 5'h1f};
  logic [1:0]  pinv[4]    = '{2'h3, 2'h2, 2'h3, 2'h1};
  logic [3:0]  thrm[4]    = '{4'h3, 4'h5, 4'h9, 4'h6};
  logic [15:0] stepv[4]   = '{16'h78, 16'h79, 16'h50, 16'h4f};
  logic [3:0]  cmdm[3]    = '{4'h7, 4'h8, 4'ha};
  always #25 core_clk = ~core_clk;
  gain_set_selector u_dut (.core_clk(core_clk), .rst(rst), .avl_req(req), .avl_rsp(rsp), .meas(meas),
    .ctl_mode(ctl_mode), .gain_in_closed(pin_closed), .gain_in_assigned(pin_assigned), .second_gain_r(sel));
  gain_pin_host u_host (.close_req(close_req), .assign_req(assign_req), .gain_in_closed(pin_closed),
    .gain_in_assigned(pin_assigned));
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{address: a, read: !w, write: w, writedata: d, byteenable: be};
    do @(posedge core_clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '{address: a, read: 1'b0, write: 1'b0, writedata: d, byteenable: be};
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    acc(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic mag(input logic [15:0] v);
    meas.torque_mag <= v;
    meas.speed_cmd_mag <= v;
    meas.speed_mag <= v;
    meas.dev_enc_mag <= v;
    meas.dev_ext_mag <= v;
  endtask : mag
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h10);
    rd(ADDR_DELAY, 32'ha);
    rd(ADDR_LEVEL, 32'h0);
    rd(ADDR_HYST, 32'h0);
    rd(4'h2, 32'h0);
    acc(ADDR_DELAY, 1'b1, 32'h3fff);
    rd(ADDR_DELAY, 32'h2710);
    acc(ADDR_LEVEL, 1'b1, 32'h7fff);
    rd(ADDR_LEVEL, 32'h4e20);
    acc(ADDR_HYST, 1'b1, 32'h7fff);
    rd(ADDR_HYST, 32'h4e20);
    be = 4'h1;
    acc(ADDR_DELAY, 1'b1, 32'h5);
    be = 4'hf;
    rd(ADDR_DELAY, 32'h2710);
    acc(ADDR_LEVEL, 1'b1, 32'h64);
    acc(ADDR_HYST, 1'b1, 32'h14);
    acc(ADDR_DELAY, 1'b1, 32'h0);
    $display("test settings finished");
    foreach (fixm[i]) begin
      acc(ADDR_CTRL, 1'b1, {27'h0, fixm[i]});
      tick(3);
      chk(sel, fixm[i] == 5'h11);
    end
    acc(ADDR_CTRL, 1'b1, 32'h12);
    foreach (pinv[i]) begin
      assign_req <= pinv[i][1];
      close_req <= pinv[i][0];
      tick(10);
      chk(sel, pinv[i] == 2'h3);
    end
    $display("test fixed and pin finished");
    foreach (thrm[i]) begin
      acc(ADDR_CTRL, 1'b1, {28'h1, thrm[i]});
      foreach (stepv[j]) begin
        mag(stepv[j]);
        tick(4);
        chk(sel, j inside {1, 2});
      end
    end
    ctl_mode <= 2'h1;
    meas.dev_enc_mag <= 16'h79;
    tick(4);
    chk(sel, 0);
    meas.dev_ext_mag <= 16'h79;
    tick(4);
    chk(sel, 1);
    ctl_mode <= 2'h0;
    mag(16'h4f);
    tick(2);
    mag(16'h79);
    tick(4);
    chk(sel, 0);
    ctl_mode <= 2'h2;
    $display("test thresholds finished");
    foreach (cmdm[i]) begin
      acc(ADDR_CTRL, 1'b1, {28'h1, cmdm[i]});
      meas.pos_cmd_nonzero <= cmdm[i] != 4'h8;
      meas.pos_complete <= cmdm[i] != 4'h8;
      tick(4);
      chk(sel, 1);
      meas.pos_cmd_nonzero <= 1'b0;
      meas.pos_complete <= 1'b1;
      mag(16'h50);
      tick(4);
      chk(sel, cmdm[i] == 4'ha);
      mag(16'h4f);
      tick(4);
      chk(sel, 0);
    end
    $display("test command modes finished");
    acc(ADDR_DELAY, 1'b1, 32'h1);
    acc(ADDR_CTRL, 1'b1, 32'h13);
    mag(16'h79);
    tick(4);
    chk(sel, 1);
    mag(16'h4f);
    tick(1000);
    mag(16'h5a);
    tick(2);
    mag(16'h4f);
    tick(1995);
    chk(sel, 1);
    tick(12);
    chk(sel, 0);
    acc(ADDR_DELAY, 1'b1, 32'h0);
    mag(16'h0);
    acc(ADDR_LEVEL, 1'b1, 32'h32);
    acc(ADDR_HYST, 1'b1, 32'h64);
    mag(16'h64);
    tick(4);
    chk(sel, 0);
    mag(16'h65);
    tick(4);
    chk(sel, 1);
    mag(16'h0);
    tick(4);
    chk(sel, 1);
    rd(ADDR_CTRL, 32'h113);
    $display("test delay and hysteresis finished");
    complete_run();
  end
endmodule : tb_gain_set_selector
`default_nettype wire
